/* File: hw/sac_ctrl.sv */
// Conversion sequencer, result holder and read port of a 12-bit successive-approximation converter.
`timescale 1ns/1ps
`default_nettype none

module sac_ctrl
  import sac_pkg::*;
#(
  parameter int unsigned RW = sac_pkg::RES_W
) (
  // Clock and reset.
  input  wire logic          mclk,
  input  wire logic          rst,
  // Pins from the host side.
  input  wire logic          convert_start,
  input  wire logic          conversion_clock,
  input  wire logic          cs_n,
  input  wire logic          rd_n,
  // Status and result pins.
  output logic               busy_n,
  output logic [RW-1:0]      result_bus_o,
  output logic               result_bus_oe,
  // Analog core: comparator, trial code and track/hold control.
  input  wire logic          cmp_i,
  output logic [RW-1:0]      dac_code_o,
  output logic               hold_o
);
  import sac_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  localparam int unsigned NSYNC = 5;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic             cvs_prev_r;
  logic             ck_prev_r;
  logic             cvs_edge;
  logic             ck_edge;
  logic             cmp_s;
  logic             rd_req;

  assign pin_raw = {convert_start, conversion_clock, cs_n, rd_n, cmp_i};

  // Every pin is foreign to mclk, so each passes two flops before use.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Idle levels, so select and read never look active just after reset.
      sync1_r <= PIN_SYNC_RST;
      sync2_r <= PIN_SYNC_RST;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  // Edge detectors look only at the second stage.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cvs_prev_r <= 1'b0;
      ck_prev_r  <= 1'b0;
    end else begin
      cvs_prev_r <= sync2_r[4];
      ck_prev_r  <= sync2_r[3];
    end
  end

  // The start edge is sampled against mclk, not the conversion clock.
  assign cvs_edge = sync2_r[4] & ~cvs_prev_r;
  assign ck_edge  = sync2_r[3] & ~ck_prev_r;
  assign cmp_s    = sync2_r[0];
  assign rd_req   = ~sync2_r[2] & ~sync2_r[1];

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  sac_state_t        st_r;
  logic [4:0]        set_cnt_r;
  logic [3:0]        bit_r;
  logic              half_r;
  logic [RW-1:0]     sar_r;
  logic [RW-1:0]     result_r;
  logic              busy_n_r;
  logic              hold_r;
  logic              done;

  assign done = (st_r == sac_trial) && ck_edge && half_r && (bit_r == 4'h0);

  // A start edge during a conversion is ignored; restarting mid-way would
  // corrupt the held sample, and the host is not meant to do it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r      <= sac_idle;
      set_cnt_r <= EDGE_CNT_RST;
      bit_r     <= 4'h0;
      half_r    <= 1'b0;
      sar_r     <= RESULT_RST;
    end else begin
      unique case (st_r)
        sac_idle: begin
          if (cvs_edge) begin
            st_r      <= sac_settle;
            set_cnt_r <= EDGE_CNT_RST;
          end
        end
        sac_settle: begin
          // Settle edges let the held sample and comparator settle.
          if (ck_edge) begin
            if (set_cnt_r == 5'(SETTLE_EDGES - 1)) begin
              st_r   <= sac_trial;
              sar_r  <= TRIAL_MSB[RW-1:0];
              bit_r  <= 4'(RW - 1);
              half_r <= 1'b0;
            end else begin
              set_cnt_r <= set_cnt_r + 5'h01;
            end
          end
        end
        sac_trial: begin
          // Two conversion clock edges per bit: DAC settles, then decide.
          if (ck_edge) begin
            if (!half_r) begin
              half_r <= 1'b1;
            end else begin
              half_r       <= 1'b0;
              sar_r[bit_r] <= cmp_s;
              if (bit_r == 4'h0) begin
                st_r <= sac_idle;
              end else begin
                sar_r[bit_r - 4'h1] <= 1'b1;
                bit_r               <= bit_r - 4'h1;
              end
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status, track/hold and result.

  // Busy falls and hold engages on the very cycle after the start edge.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_n_r <= 1'b1;
      hold_r   <= 1'b0;
    end else if (st_r == sac_idle && cvs_edge) begin
      busy_n_r <= 1'b0;
      hold_r   <= 1'b1;
    end else if (done) begin
      busy_n_r <= 1'b1;
      hold_r   <= 1'b0;
    end
  end

  // The result only changes at the end of a conversion, so a late reader
  // never sees a half-built code. Codes pass straight through.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_r <= RESULT_RST[RW-1:0];
    end else if (done) begin
      result_r <= {sar_r[RW-1:1], cmp_s};
    end
  end

  // Drivers are enabled only while idle and selected for read.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_bus_oe <= 1'b0;
    end else begin
      // A start edge shuts them at once, so none stand in a conversion's first cycle.
      result_bus_oe <= rd_req && busy_n_r && !done && st_r == sac_idle && !cvs_edge;
    end
  end

  // Outputs come from flops.
  assign busy_n       = busy_n_r;
  assign hold_o       = hold_r;
  assign dac_code_o   = sar_r;
  assign result_bus_o = result_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  localparam int unsigned EMIN = CONV_MIN_PER;
  localparam int unsigned EMAX = CONV_MAX_PER;

  logic [5:0]  ck_seen_r;
  logic [10:0] mcyc_r;

  // Helper counters of conversion clock edges and mclk cycles per conversion.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ck_seen_r <= 6'h00;
      mcyc_r    <= 11'h000;
    end else if (st_r == sac_idle && cvs_edge) begin
      ck_seen_r <= 6'h00;
      mcyc_r    <= 11'h000;
    end else if (!busy_n_r) begin
      ck_seen_r <= ck_seen_r + {5'h00, ck_edge};
      mcyc_r    <= mcyc_r + 11'h001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  start_hold_a: assert property (
    (st_r == sac_idle && cvs_edge) |=> (hold_r && !busy_n_r && st_r == sac_settle))
    else $error("start edge did not enter hold and busy");

  conv_len_a: assert property (
    $rose(busy_n_r) |-> (ck_seen_r >= 6'(EMIN) && ck_seen_r <= 6'(EMAX)))
    else $error("conversion length outside clock period window");

  conv_time_a: assert property (
    !busy_n_r |-> mcyc_r <= 11'(CONV_MAX_CYC))
    else $error("conversion exceeded its time limit");

  busy_hold_a: assert property (
    (st_r != sac_idle) |-> !busy_n_r)
    else $error("busy high during conversion");

  bus_off_a: assert property (
    (!busy_n_r || st_r != sac_idle) |-> !result_bus_oe)
    else $error("data drivers on during conversion");

  busy_done_a: assert property (
    $rose(busy_n_r) |-> (!hold_r && result_bus_o == $past({sar_r[RW-1:1], cmp_s})))
    else $error("busy rose without a fresh result");

  read_drive_a: assert property (
    (rd_req && busy_n_r && st_r == sac_idle) ##1 (st_r == sac_idle) |-> result_bus_oe)
    else $error("read while idle did not enable data");

  msb_trial_a: assert property (
    (st_r == sac_settle) ##1 (st_r == sac_trial) |-> dac_code_o == TRIAL_MSB[RW-1:0])
    else $error("first trial is not midscale");

  busy_cause_a: assert property (
    $fell(busy_n_r) |-> $past(cvs_edge) ##0 $stable(result_bus_o) [*2])
    else $error("busy fell without a start edge or result moved");

  // Drivers may only stand while idle and not busy.
  oe_idle_a: assert property (
    result_bus_oe |-> (busy_n_r && st_r == sac_idle))
    else $error("data drivers on outside idle");

  // A start edge shuts the drivers on the next cycle, even during a read.
  start_off_a: assert property (
    (st_r == sac_idle && cvs_edge) |=> !result_bus_oe)
    else $error("drivers still on after a start edge");

  // The held result moves only when a conversion finishes.
  result_keep_a: assert property (
    !done |=> $stable(result_bus_o))
    else $error("result changed outside conversion end");

  // Each decision stores the synchronised comparator into the bit under trial.
  bit_decide_a: assert property (
    (st_r == sac_trial && ck_edge && half_r) |=> dac_code_o[$past(bit_r)] == $past(cmp_s))
    else $error("decided bit does not match comparator");

  // After a decision the next lower bit becomes the trial bit.
  next_trial_a: assert property (
    (st_r == sac_trial && ck_edge && half_r && bit_r != 4'h0) |=>
      ((bit_r == $past(bit_r) - 4'h1) && dac_code_o[bit_r]))
    else $error("next trial bit not set");

  // The settle count never passes its last edge.
  settle_cnt_a: assert property (
    (st_r == sac_settle) |-> (set_cnt_r < 5'(SETTLE_EDGES)))
    else $error("settle counter overran");

  // A start edge during the bit trials must not restart the sequencer.
  restart_ignored_a: assert property (
    (st_r == sac_trial && cvs_edge) |=> (st_r != sac_settle))
    else $error("start edge restarted a running conversion");

  // Track/hold is released only while idle and not busy.
  hold_track_a: assert property (
    !hold_r |-> (st_r == sac_idle && busy_n_r))
    else $error("track mode during a conversion");

endmodule : sac_ctrl
`default_nettype wire

/* File: hw/sac_pkg.sv */
// Shared constants and types for the successive-approximation conversion control.
package sac_pkg;

  // Result width and the conversion clock edge budget.
  localparam int unsigned RES_W         = 12;
  localparam int unsigned SETTLE_EDGES  = 3;
  localparam int unsigned EDGES_PER_BIT = 2;
  localparam int unsigned CONV_EDGES    = SETTLE_EDGES + EDGES_PER_BIT * RES_W;
  localparam int unsigned CONV_MIN_PER  = 26;
  localparam int unsigned CONV_MAX_PER  = 28;

  // Time limits, in their own units, and the derived cycle counts at mclk.
  localparam int unsigned MCLK_PERIOD_NS = 20;
  localparam int unsigned CONV_MAX_NS    = 12000;
  localparam int unsigned CONV_MAX_CYC   = CONV_MAX_NS / MCLK_PERIOD_NS;

  // Values after reset, and the midscale first trial code.
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [11:0] TRIAL_MSB  = 12'h800;
  localparam logic [4:0]  EDGE_CNT_RST = 5'h00;
  // Synchroniser reset: select and read sit at their idle high level.
  localparam logic [4:0]  PIN_SYNC_RST = 5'h06;

  // Sequencer states.
  typedef enum logic [1:0] {
    sac_idle,
    sac_settle,
    sac_trial
  } sac_state_t;

endpackage : sac_pkg

/* File: verif/sac_host_model.sv */
// Far-side model: the conversion clock source and an ideal analog comparator.
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
  // Trial code and the held input level, as a code.
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] level,
  // Clock and comparator result.
  output logic             conversion_clock,
  output logic             cmp
);
  // Free-running 2.5 MHz clock at even mark/space.
  initial conversion_clock = 1'b0;
  always #200 conversion_clock = ~conversion_clock;

  // Comparator high while the held input reaches the trial code.
  assign cmp = (level >= dac_code);
endmodule : sac_host_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the conversion control.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sac_pkg::*;
  logic        mclk, rst, convert_start, cs_n, rd_n, conversion_clock, cmp, busy_n, oe, hold;
  logic [11:0] result_bus, dac_code, level, prev;
  int          mismatches, cmp_count, cyc;
  logic [11:0] codes [7] = '{12'h000, 12'h001, 12'hffe, 12'hfff, 12'h7ff, 12'h800, 12'ha5a};

  sac_ctrl i_dut (.mclk(mclk), .rst(rst), .convert_start(convert_start), .conversion_clock(conversion_clock),
    .cs_n(cs_n), .rd_n(rd_n), .busy_n(busy_n), .result_bus_o(result_bus), .result_bus_oe(oe),
    .cmp_i(cmp), .dac_code_o(dac_code), .hold_o(hold));
  sac_host_model i_host (.dac_code(dac_code), .level(level), .conversion_clock(conversion_clock), .cmp(cmp));

  // Clock and a hang guard well above seven conversions.
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Outputs must sit at their idle values while reset is held.
  task automatic check_reset();
    repeat (16) @(posedge mclk);
    chk(busy_n, 1'b1);
    chk(oe, 1'b0);
    chk(hold, 1'b0);
    chk(result_bus, RESULT_RST);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(oe, 1'b0);
    chk(busy_n, 1'b1);
    $display("test reset done");
  endtask : check_reset

  // Read the old result, end the read as the start rises with select still low, send one stray start
  // edge, then read the new code and leave time for acquisition before the next start.
  task automatic convert_code(input logic [11:0] code);
    int   n;
    logic oe_seen;
    n = 0;
    oe_seen = 1'b0;
    level <= code;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(oe, 1'b1);
    chk(result_bus, prev);
    rd_n <= 1'b1;
    convert_start <= 1'b1;
    while (busy_n === 1'b1 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    chk(n < 8, 1'b1);
    chk(hold, 1'b1);
    @(posedge mclk);
    n++;
    // The stray rising edge at 200 must be ignored, so the count stays in range.
    while (busy_n === 1'b0 && n < 700) begin
      oe_seen = oe_seen | oe;
      convert_start <= (n < 100 || (n >= 200 && n < 300));
      @(posedge mclk);
      n++;
    end
    chk(oe_seen, 1'b0);
    chk(n >= 520 && n <= 600, 1'b1);
    rd_n <= 1'b0;
    repeat (5) @(posedge mclk);
    chk(busy_n, 1'b1);
    chk(hold, 1'b0);
    chk(oe, 1'b1);
    chk(result_bus, code);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(oe, 1'b0);
    prev = code;
    // Acquisition gap: keeps start to start above the slowest allowed sampling period.
    repeat (250) @(posedge mclk);
    $display("test convert %h done", code);
  endtask : convert_code

  ////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    convert_start = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    level = 12'h000;
    prev = RESULT_RST;
    check_reset();
    foreach (codes[i]) begin
      convert_code(codes[i]);
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
